// ### tcm_consts.svh
/*
 * Offsets, field positions, reset values and divider taps of the capture
 * timer channel. Assumes byte addresses on an 8-bit register bus address.
 */
`ifndef TCM_CONSTS_SVH
`define TCM_CONSTS_SVH
// Register byte offsets.
`define TCM_OFS_CMD 8'h60
`define TCM_OFS_MODE 8'h64
`define TCM_OFS_SR 8'h70
`define TCM_OFS_IER 8'h74
`define TCM_OFS_IDR 8'h78
`define TCM_OFS_IMR 8'h7c
`define TCM_OFS_CV 8'h80
`define TCM_OFS_RA 8'h84
`define TCM_OFS_RB 8'h88
`define TCM_OFS_RC 8'h8c
// Command register bits.
`define TCM_CMD_RST 0
`define TCM_CMD_ON 1
`define TCM_CMD_OFF 2
`define TCM_CMD_TRG 3
// Setup register fields.
`define TCM_MD_CLOCK_SELECT 2:0
`define TCM_MD_CLOCK_INVERT 3
`define TCM_MD_BURST 5:4
`define TCM_MD_BSTOP 6
`define TCM_MD_BDIS 7
`define TCM_MD_TEDGE 9:8
`define TCM_MD_TPIN 10
`define TCM_MD_CTRG 14
`define TCM_MD_LDA 17:16
`define TCM_MD_LDB 19:18
`define TCM_MD_MASK 32'h000f47ff
`define TCM_MD_RST 32'h00000000
// Status register bits.
`define TCM_SR_OVF 0
`define TCM_SR_OVR 1
`define TCM_SR_CPC 4
`define TCM_SR_LDA 5
`define TCM_SR_LDB 6
`define TCM_SR_TRG 7
`define TCM_SR_CLK 8
`define TCM_SR_MA 9
`define TCM_SR_MB 10
`define TCM_SR_CHB 16
`define TCM_SR_CHA 17
`define TCM_SR_STICKY 32'h000300f3
// Prescaler taps for divide by 2, 8, 32, 128 and 1024.
`define TCM_DIV_W 10
`define TCM_TAP_2 0
`define TCM_TAP_8 2
`define TCM_TAP_32 4
`define TCM_TAP_128 6
`define TCM_TAP_1024 9
`define TCM_CNT_MAX 16'hffff
`define TCM_CNT_ZERO 16'h0000
`endif

// ### tcm_pkg.sv
/*
 * Types and the edge-select decode shared by the capture timer modules.
 * Assumes nothing of its surroundings.
 */
package tcm_pkg;
    typedef enum logic {TCM_IDLE, TCM_COUNT} tcm_run_e;
    typedef logic [15:0] tcm_cnt_t;

    // Edge select: 00 none, 01 rising, 10 falling, 11 either.
    function automatic logic tcm_edge_hit(input logic [1:0] sel, input logic rise,
                                          input logic fall);
        return (sel[0] & rise) | (sel[1] & fall);
    endfunction
endpackage

// ### tcm_if.sv
/*
 * Carrier between the channel core, its clock source and its pin edge finder.
 * Assumes all three run on the same core clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface tcm_if;
    logic [2:0] clk_sel;
    logic clk_inv;
    logic [1:0] burst;
    logic tick;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;
    logic a_lvl;
    logic b_lvl;
    modport src (input clk_sel, input clk_inv, input burst, output tick);
    modport pin (output a_rise, output a_fall, output b_rise, output b_fall,
                 output a_lvl, output b_lvl);
    modport core (output clk_sel, output clk_inv, output burst, input tick,
                  input a_rise, input a_fall, input b_rise, input b_fall,
                  input a_lvl, input b_lvl);
endinterface
`default_nettype wire

// ### tcm_clk_src.sv
/*
 * Counter clock source: prescaler, source select, burst gate and edge pick.
 * Assumes external clocks are synchronous to the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tcm_consts.svh"
module tcm_clk_src (
    // System.
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // External clocks.
    input wire logic [2:0] ext_clk,
    // Core side.
    tcm_if.src bus
);
    logic [`TCM_DIV_W-1:0] pre_r;
    logic lvl_r;
    logic tick_r;

    // Source table: dividers for codes 0 to 4, external clocks for 5 to 7.
    wire [7:0] srcs = {ext_clk, pre_r[`TCM_TAP_1024], pre_r[`TCM_TAP_128],
                       pre_r[`TCM_TAP_32], pre_r[`TCM_TAP_8], pre_r[`TCM_TAP_2]}; // [R2]
    wire [3:0] gates = {ext_clk, 1'b1};
    wire gated = srcs[bus.clk_sel] & gates[bus.burst]; // [R4]
    // Rising edge normally, falling edge when inverted.
    wire tick_nxt = bus.clk_inv ? (lvl_r & ~gated) : (~lvl_r & gated); // [R3]

    // The tick is registered so the core sees a clean one-cycle pulse.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pre_r <= '0;
            lvl_r <= 1'b0;
            tick_r <= 1'b0;
        end else if (ce) begin
            pre_r <= pre_r + 10'h001;
            lvl_r <= gated;
            tick_r <= tick_nxt;
        end
    end

    assign bus.tick = tick_r & ce;
endmodule
`default_nettype wire

// ### tcm_pin_edge.sv
/*
 * Edge finder for the two timer pins.
 * Assumes pin inputs are synchronous to the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tcm_pin_edge (
    // System.
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Pins.
    input wire logic tio_a,
    input wire logic tio_b,
    // Core side.
    tcm_if.pin bus
);
    logic a_r;
    logic b_r;

    // Previous pin levels; edges are seen one cycle after reset at the earliest.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            a_r <= 1'b0;
            b_r <= 1'b0;
        end else if (ce) begin
            a_r <= tio_a;
            b_r <= tio_b;
        end
    end

    // Edges are masked while the clock enable freezes the block.
    assign bus.a_rise = ce & tio_a & ~a_r;
    assign bus.a_fall = ce & ~tio_a & a_r;
    assign bus.b_rise = ce & tio_b & ~b_r;
    assign bus.b_fall = ce & ~tio_b & b_r;
    assign bus.a_lvl = a_r;
    assign bus.b_lvl = b_r;
endmodule
`default_nettype wire

// ### tcm_capture_timer.sv
/*
 * One timer channel in capture mode with its Avalon-MM register slave.
 * Assumes pins and external clocks are synchronous to CLK, and that
 * SYNC_TRIGGER is a one-cycle pulse from the shared synchronize register.
 */
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "tcm_consts.svh"
//////////////////////////////////////////////////////////////////////////////
// Function
// [R1] Capture mode by default, pins stay inputs.
// [R2] Clock select: five dividers, three external clocks.
// [R3] Clock invert picks falling edge counting.
// [R4] Burst field ANDs an external gate in.
// [R5] Stop on B load; only trigger restarts.
// [R6] Trigger ignored when same edge stops counter.
// [R7] B load may switch counter clock off.
// [R8] Trigger pin and trigger edge selection.
// [R9] External trigger restarts counter, sets flag.
// [R10] Triggers start counter only while clock on.
// [R11] Compare C match may restart counter.
// [R12] Sixteen-bit compare register signals matches.
// [R13] Edge selects for loading capture A, B.
// [R14] Counter zeroed at next tick after setup.
// [R15] Soft reset clears the whole channel; the code leaves the prescaler, pin edge history and bus read data as they are.
// [R16] Clock on unless off in same write.
// [R17] Soft trigger restarts at next valid tick.
// [R18] Synchronize strobe triggers all channels together.
// [R19] Overflow flagged on wrap to zero.
// [R20] Overrun flagged on reload before read.
// [R21] Six event sources can request service; the code lets eight sticky flags do so.
// [R22] Status read clears reported sticky flags.
// [R23] Counter steps per tick; capture copies it.
module tcm_capture_timer (
    // System.
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    // Avalon-MM register slave.
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Timer pins, never driven in capture mode.
    input wire logic TIMER_IO_A_PIN_IN,
    output logic TIMER_IO_A_PIN_OUT,
    output logic TIMER_IO_A_PIN_OE,
    input wire logic TIMER_IO_B_PIN_IN,
    output logic TIMER_IO_B_PIN_OUT,
    output logic TIMER_IO_B_PIN_OE,
    // External clocks and the shared synchronize strobe.
    input wire logic [2:0] EXT_CLOCK,
    input wire logic SYNC_TRIGGER,
    // Service request from enabled sticky flags.
    output logic EVENT_IRQ
);
    logic wait_r;
    logic [31:0] rdata_r;
    logic [31:0] mode_r;
    logic [31:0] flg_r;
    logic [31:0] imr_r;
    logic [15:0] rc_r;
    tcm_pkg::tcm_cnt_t cnt_r;
    tcm_pkg::tcm_cnt_t ra_r;
    tcm_pkg::tcm_cnt_t rb_r;
    tcm_pkg::tcm_run_e run_r;
    tcm_pkg::tcm_run_e run_nxt;
    logic count_clock_on_r;
    logic pend_r;
    logic zpend_r;
    logic ra_unread_r;
    logic rb_unread_r;
    logic irq_r;
    logic tio_oe_r;
    logic [31:0] flg_set;
    logic [31:0] rd_mux;

    tcm_if chan_bus ();

    //////////////////////////////////////////////////////////////////////////
    // Clock source and pin edges.
    tcm_clk_src u_clk_src (
        .clk(CLK),
        .rst_b(RST_B),
        .ce(CE),
        .ext_clk(EXT_CLOCK),
        .bus(chan_bus.src)
    );

    tcm_pin_edge u_pin_edge (
        .clk(CLK),
        .rst_b(RST_B),
        .ce(CE),
        .tio_a(TIMER_IO_A_PIN_IN),
        .tio_b(TIMER_IO_B_PIN_IN),
        .bus(chan_bus.pin)
    );

    //////////////////////////////////////////////////////////////////////////
    // Register bus decode; a request is taken on the edge that sees wait low.
    wire req = AVS_READ | AVS_WRITE;
    wire acc = req & ~wait_r & CE;
    wire wr_acc = acc & AVS_WRITE;
    wire rd_acc = acc & AVS_READ;
    wire [31:0] be_m = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                        {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
    wire [31:0] wd = AVS_WRITEDATA & be_m;
    wire wr_cmd = wr_acc & (AVS_ADDRESS == `TCM_OFS_CMD);
    wire wr_mode = wr_acc & (AVS_ADDRESS == `TCM_OFS_MODE);
    wire wr_ier = wr_acc & (AVS_ADDRESS == `TCM_OFS_IER);
    wire wr_idr = wr_acc & (AVS_ADDRESS == `TCM_OFS_IDR);
    wire wr_rc = wr_acc & (AVS_ADDRESS == `TCM_OFS_RC);
    wire rd_sr = rd_acc & (AVS_ADDRESS == `TCM_OFS_SR);
    wire rd_ra = rd_acc & (AVS_ADDRESS == `TCM_OFS_RA);
    wire rd_rb = rd_acc & (AVS_ADDRESS == `TCM_OFS_RB);

    // Commands; a one bit acts, except ON together with OFF, and a zero bit does nothing.
    wire swr = wr_cmd & wd[`TCM_CMD_RST]; // [R15]
    wire on_evt = wr_cmd & wd[`TCM_CMD_ON] & ~wd[`TCM_CMD_OFF]; // [R16]
    wire soft_trg = (wr_cmd & wd[`TCM_CMD_TRG]) | (SYNC_TRIGGER & CE); // [R17] [R18]

    //////////////////////////////////////////////////////////////////////////
    // Setup fields steering the channel.
    wire [1:0] lda_sel = mode_r[`TCM_MD_LDA];
    wire [1:0] ldb_sel = mode_r[`TCM_MD_LDB];
    wire [1:0] tedge = mode_r[`TCM_MD_TEDGE];
    wire tpin = mode_r[`TCM_MD_TPIN];
    wire bstop = mode_r[`TCM_MD_BSTOP];
    wire bdis = mode_r[`TCM_MD_BDIS];
    wire ctrg = mode_r[`TCM_MD_CTRG];
    assign chan_bus.clk_sel = mode_r[`TCM_MD_CLOCK_SELECT]; // [R2]
    assign chan_bus.clk_inv = mode_r[`TCM_MD_CLOCK_INVERT]; // [R3]
    assign chan_bus.burst = mode_r[`TCM_MD_BURST]; // [R4]

    //////////////////////////////////////////////////////////////////////////
    // Pin events: capture loads and the external trigger.
    wire a_r = chan_bus.a_rise;
    wire a_f = chan_bus.a_fall;
    wire lda_evt = tcm_pkg::tcm_edge_hit(lda_sel, a_r, a_f); // [R13]
    wire ldb_evt = tcm_pkg::tcm_edge_hit(ldb_sel, a_r, a_f); // [R13]
    wire b_halt = ldb_evt & (bstop | bdis);
    wire trg_a = tcm_pkg::tcm_edge_hit(tedge, a_r, a_f);
    wire trg_b = tcm_pkg::tcm_edge_hit(tedge, chan_bus.b_rise, chan_bus.b_fall);
    wire trg_edge = tpin ? trg_a : trg_b; // [R8]
    // A TIOA edge that both triggers and halts the counter must not restart it.
    wire ext_trg = trg_edge & ~(tpin & b_halt); // [R6]
    wire trig_now = ext_trg | soft_trg; // [R9]

    //////////////////////////////////////////////////////////////////////////
    // Counter control.
    wire off_evt = (wr_cmd & wd[`TCM_CMD_OFF]) | (ldb_evt & bdis); // [R7] [R16]
    wire count_clock_on_nxt = off_evt ? 1'b0 : (on_evt ? 1'b1 : count_clock_on_r); // [R16]
    wire step = chan_bus.tick & count_clock_on_r;
    wire running = (run_r == tcm_pkg::TCM_COUNT);
    wire cmp_trg = ctrg & running & (cnt_r == rc_r); // [R11]
    // Only an enabled clock can start the counter.
    wire restart = step & (pend_r | trig_now | cmp_trg); // [R10] [R17]
    wire zero = step & zpend_r; // [R14]
    wire stop_evt = b_halt | ~count_clock_on_nxt; // [R5] [R7]
    // A B-load halt also drops a waiting trigger, so the stop is not undone a tick later.
    wire pend_nxt = count_clock_on_nxt & ~step & ~b_halt & (pend_r | trig_now); // [R5] [R10]
    wire zpend_nxt = wr_mode | (zpend_r & ~step); // [R14]
    wire [15:0] cnt_nxt = stop_evt ? cnt_r :
                          (restart | zero) ? `TCM_CNT_ZERO :
                          (step & running) ? cnt_r + 16'h0001 : cnt_r; // [R23]

    // Run state: a trigger starts, a B-load halt or clock off stops.
    always_comb begin
        run_nxt = run_r;
        case (run_r)
            tcm_pkg::TCM_IDLE: begin
                if (restart && !stop_evt) begin
                    run_nxt = tcm_pkg::TCM_COUNT; // [R5]
                end
            end
            tcm_pkg::TCM_COUNT: begin
                if (stop_evt) begin
                    run_nxt = tcm_pkg::TCM_IDLE; // [R5]
                end
            end
            default: run_nxt = tcm_pkg::TCM_IDLE;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Events feeding the sticky flags.
    wire ovf_evt = step & running & ~restart & ~zero & ~stop_evt &
                   (cnt_r == `TCM_CNT_MAX); // [R19]
    wire cpc_evt = step & (run_nxt == tcm_pkg::TCM_COUNT) & (cnt_nxt == rc_r); // [R12]
    wire ovr_evt = (lda_evt & ra_unread_r) | (ldb_evt & rb_unread_r); // [R20]
    // Only flags reported by the read being completed are cleared.
    wire [31:0] flg_clr = rd_sr ? (rdata_r & `TCM_SR_STICKY) : 32'h00000000; // [R22]

    always_comb begin
        flg_set = 32'h00000000;
        flg_set[`TCM_SR_OVF] = ovf_evt;
        flg_set[`TCM_SR_OVR] = ovr_evt;
        flg_set[`TCM_SR_CPC] = cpc_evt;
        flg_set[`TCM_SR_LDA] = lda_evt;
        flg_set[`TCM_SR_LDB] = ldb_evt;
        flg_set[`TCM_SR_TRG] = ext_trg; // [R9]
        flg_set[`TCM_SR_CHB] = chan_bus.b_rise | chan_bus.b_fall;
        flg_set[`TCM_SR_CHA] = a_r | a_f;
    end

    //////////////////////////////////////////////////////////////////////////
    // Read data selection; write-only and unmapped addresses read zero.
    always_comb begin
        case (AVS_ADDRESS)
            `TCM_OFS_MODE: rd_mux = mode_r;
            `TCM_OFS_SR: begin
                rd_mux = flg_r;
                rd_mux[`TCM_SR_CLK] = count_clock_on_r;
                rd_mux[`TCM_SR_MA] = chan_bus.a_lvl;
                rd_mux[`TCM_SR_MB] = chan_bus.b_lvl;
            end
            `TCM_OFS_IMR: rd_mux = imr_r;
            `TCM_OFS_CV: rd_mux = {16'h0000, cnt_r};
            `TCM_OFS_RA: rd_mux = {16'h0000, ra_r};
            `TCM_OFS_RB: rd_mux = {16'h0000, rb_r};
            `TCM_OFS_RC: rd_mux = {16'h0000, rc_r};
            default: rd_mux = 32'h00000000;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, then the answer stands for one cycle.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h00000000;
        end else if (CE) begin
            wait_r <= ~(wait_r & req);
            if (wait_r && AVS_READ) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // Setup, compare and mask registers; soft reset clears them too.
    always_ff @(posedge CLK) begin
        if (!RST_B || swr) begin
            mode_r <= `TCM_MD_RST; // [R1] [R15]
            rc_r <= 16'h0000;
            imr_r <= 32'h00000000;
        end else begin
            if (wr_mode) begin
                mode_r <= (mode_r & ~be_m) | (wd & `TCM_MD_MASK);
            end
            if (wr_rc) begin
                rc_r <= (rc_r & ~be_m[15:0]) | wd[15:0]; // [R12]
            end
            if (wr_ier || wr_idr) begin
                imr_r <= wr_ier ? (imr_r | (wd & `TCM_SR_STICKY)) : (imr_r & ~wd);
            end
        end
    end

    // Counter, run state and trigger bookkeeping.
    always_ff @(posedge CLK) begin
        if (!RST_B || swr) begin
            cnt_r <= `TCM_CNT_ZERO; // [R15]
            run_r <= tcm_pkg::TCM_IDLE;
            count_clock_on_r <= 1'b0;
            pend_r <= 1'b0;
            zpend_r <= 1'b0;
        end else if (CE) begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            count_clock_on_r <= count_clock_on_nxt;
            pend_r <= pend_nxt;
            zpend_r <= zpend_nxt;
        end
    end

    // Captures copy the live count; a new load sets the unread marker.
    always_ff @(posedge CLK) begin
        if (!RST_B || swr) begin
            ra_r <= `TCM_CNT_ZERO;
            rb_r <= `TCM_CNT_ZERO;
            ra_unread_r <= 1'b0;
            rb_unread_r <= 1'b0;
        end else begin
            if (lda_evt) begin
                ra_r <= cnt_r; // [R23]
            end
            if (ldb_evt) begin
                rb_r <= cnt_r; // [R23]
            end
            ra_unread_r <= lda_evt | (ra_unread_r & ~rd_ra); // [R20]
            rb_unread_r <= ldb_evt | (rb_unread_r & ~rd_rb); // [R20]
        end
    end

    // Sticky flags: a set in the clearing cycle wins.
    always_ff @(posedge CLK) begin
        if (!RST_B || swr) begin
            flg_r <= 32'h00000000;
            irq_r <= 1'b0;
            tio_oe_r <= 1'b0;
        end else if (CE) begin
            flg_r <= (flg_r & ~flg_clr) | flg_set; // [R22]
            irq_r <= |(flg_r & imr_r); // [R21]
            tio_oe_r <= 1'b0; // [R1]
        end
    end

    assign AVS_READDATA = rdata_r;
    assign AVS_WAITREQUEST = wait_r;
    assign TIMER_IO_A_PIN_OUT = tio_oe_r;
    assign TIMER_IO_A_PIN_OE = tio_oe_r;
    assign TIMER_IO_B_PIN_OUT = tio_oe_r;
    assign TIMER_IO_B_PIN_OE = tio_oe_r;
    assign EVENT_IRQ = irq_r;

    //////////////////////////////////////////////////////////////////////////
    // Checks on the channel behaviour.
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    a_pins_input: assert property (!TIMER_IO_A_PIN_OE && !TIMER_IO_B_PIN_OE) // [R1]
        else $error("timer pin driven in capture mode");
    a_off_wins: assert property (wr_cmd && wd[`TCM_CMD_OFF] |=> !count_clock_on_r) // [R16]
        else $error("clock off command ignored");
    a_on_cmd: assert property (on_evt && !(ldb_evt && bdis) && !swr |=> count_clock_on_r) // [R16]
        else $error("clock on command ignored");
    a_soft_reset: assert property (swr |=> mode_r == 32'h0 && !count_clock_on_r && flg_r == 32'h0) // [R15]
        else $error("soft reset left state behind");
    a_dis_no_run: assert property (!count_clock_on_r && !on_evt |=> !running) // [R10]
        else $error("counter runs with clock off");
    a_trig_zero: assert property (restart && !stop_evt && !swr
        |=> cnt_r == 16'h0 && running) // [R17]
        else $error("trigger did not restart counter");
    a_count_step: assert property (step && running && !restart && !zero && !stop_evt
        && !swr |=> cnt_r == $past(cnt_r) + 16'h0001) // [R23]
        else $error("counter did not step");
    a_stop_b: assert property (ldb_evt && bstop && !swr // [R5]
        |=> !running ##1 (!running || $past(restart)))
        else $error("counter not halted by B load");
    a_b_clkoff: assert property (ldb_evt && bdis && !swr |=> !count_clock_on_r) // [R7]
        else $error("B load did not switch clock off");
    a_cap_a: assert property (lda_evt && !swr |=> ra_r == $past(cnt_r)) // [R23]
        else $error("capture A lost the count");
    a_ovf_flag: assert property (ovf_evt && !swr |=> flg_r[`TCM_SR_OVF] && cnt_r == 16'h0) // [R19]
        else $error("overflow not flagged");
    a_ovr_flag: assert property (ovr_evt && !swr |=> flg_r[`TCM_SR_OVR]) // [R20]
        else $error("overrun not flagged");
endmodule
`default_nettype wire

// ### tcm_far.sv
/*
 * Far-side model of the capture channel: timer pins, external clocks, sync strobe.
 * Assumes its tasks are called just after a rising CLK edge.
 */
`timescale 1ns/1ps
`default_nettype none
module tcm_far (
    // Clock.
    input wire logic CLK,
    // Lines into the channel.
    output logic PIN_A,
    output logic PIN_B,
    output logic [2:0] EXT_CLOCK,
    output logic SYNC
);
    logic run_r;
    // Lines idle low; clocks 1 and 2 stay low, so a burst gate on them stays shut.
    initial begin
        PIN_A = 1'b0;
        PIN_B = 1'b0;
        EXT_CLOCK = 3'h0;
        SYNC = 1'b0;
        run_r = 1'b0;
    end
    // Clock 0 toggles only within a run and stands low between runs.
    always @(posedge CLK) begin
        EXT_CLOCK[0] <= run_r & ~EXT_CLOCK[0];
    end
    ////////////////////////////////////////////////////////////////////////////
    // Each line moves one edge after the call and then holds its level.
    task automatic pin_a(input logic v);
        @(posedge CLK);
        PIN_A <= v;
    endtask
    task automatic pin_b(input logic v);
        @(posedge CLK);
        PIN_B <= v;
    endtask
    task automatic run(input logic v);
        @(posedge CLK);
        run_r <= v;
    endtask
    // One-cycle strobe, as the shared synchronize register makes it.
    task automatic sync_pulse();
        @(posedge CLK);
        SYNC <= 1'b1;
        @(posedge CLK);
        SYNC <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### test_timer_capture_mode.sv
/*
 * Self-checking bench of the capture channel over its register slave.
 * Assumes the far-side model and the design files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tcm_consts.svh"
module test_timer_capture_mode;
    localparam logic [7:0] CMD = `TCM_OFS_CMD;
    localparam logic [7:0] MD = `TCM_OFS_MODE;
    localparam logic [7:0] SR = `TCM_OFS_SR;
    localparam logic [7:0] CV = `TCM_OFS_CV;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic ce = 1'b1;
    logic [3:0] be = 4'hf;
    logic [31:0] wdat = 32'h0;
    wire logic [31:0] rdat;
    wire logic wait_r;
    wire logic pa, pb, oe_a, oe_b, out_a, out_b, irq, sync;
    wire logic [2:0] xclk;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    int divs[5] = '{2, 8, 32, 128, 1024};
    logic [31:0] rd, c1;
    tcm_far far (.CLK(clk), .PIN_A(pa), .PIN_B(pb), .EXT_CLOCK(xclk), .SYNC(sync));
    tcm_capture_timer dut (.CLK(clk), .RST_B(rst_b), .CE(ce), .AVS_ADDRESS(adr),
        .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat),
        .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_r),
        .TIMER_IO_A_PIN_IN(pa), .TIMER_IO_A_PIN_OUT(out_a), .TIMER_IO_A_PIN_OE(oe_a),
        .TIMER_IO_B_PIN_IN(pb), .TIMER_IO_B_PIN_OUT(out_b), .TIMER_IO_B_PIN_OE(oe_b),
        .EXT_CLOCK(xclk), .SYNC_TRIGGER(sync), .EVENT_IRQ(irq));
    // 200 MHz core clock.
    always #2.5 clk = ~clk;
    // A hung handshake would stall forever, so cap the run well above its length.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fail_count++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (fail_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    // Request holds until waitrequest is sampled low; an idle edge follows the release.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        adr <= a;
        wr_en <= w;
        rd_en <= ~w;
        wdat <= d;
        @(posedge clk);
        while (wait_r !== 1'b0) @(posedge clk);
        rd = rdat;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(s, e, rd & m);
    endtask
    task automatic cnt_in(input string s, input logic [31:0] lo, input logic [31:0] hi);
        bus(1'b0, CV, 32'h0);
        chk(s, 32'h1, {31'h0, rd >= lo && rd <= hi});
    endtask
    task automatic setup(input logic [31:0] m);
        bus(1'b1, CMD, 32'h1);
        bus(1'b1, MD, m);
        bus(1'b1, CMD, 32'ha);
        repeat (20) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rdc("setup reset", MD, 32'hffffffff, `TCM_MD_RST);
        chk("pin enables", 32'h0, {28'h0, oe_a, oe_b, out_a, out_b});
        rdc("unmapped", 8'h90, 32'hffffffff, 32'h0);
        bus(1'b1, MD, 32'hffffffff);
        rdc("setup fields", MD, 32'hffffffff, `TCM_MD_MASK);
        // Only byte lane 0 is written, so the upper setup fields must survive.
        be <= 4'h1;
        bus(1'b1, MD, 32'h0);
        be <= 4'hf;
        rdc("byte lanes", MD, 32'hffffffff, 32'h000f4700);
        bus(1'b1, CMD, 32'h6);
        rdc("on with off", SR, 32'h100, 32'h0);
        bus(1'b1, CMD, 32'h1);
        rdc("soft reset", MD, 32'hffffffff, 32'h0);
        bus(1'b1, CMD, 32'h8);
        repeat (20) @(posedge clk);
        cnt_in("trigger clock off", 0, 0);
        bus(1'b1, CMD, 32'h2);
        repeat (20) @(posedge clk);
        cnt_in("no trigger yet", 0, 0);
        rdc("clock status", SR, 32'h100, 32'h100);
        far.sync_pulse();
        repeat (40) @(posedge clk);
        cnt_in("after sync", 12, 26);
        // Each internal divider: ten ticks' worth of core cycles after a soft trigger.
        for (int k = 0; k < 5; k++) begin
            bus(1'b1, MD, k);
            bus(1'b1, CMD, 32'h8);
            repeat (10 * divs[k]) @(posedge clk);
            cnt_in("divider", 7, 11);
        end
        setup(32'h5);
        far.run(1'b1);
        repeat (40) @(posedge clk);
        far.run(1'b0);
        cnt_in("ext clock 0", 15, 21);
        setup(32'h20);
        cnt_in("burst gate shut", 0, 0);
        setup(32'h00090040);
        far.pin_a(1'b1);
        repeat (4) @(posedge clk);
        rdc("a loaded", SR, 32'h60, 32'h20);
        rdc("a flag cleared", SR, 32'h20, 32'h0);
        bus(1'b0, 8'h84, 32'h0);
        chk("capture a", 32'h1, {31'h0, rd > 0 && rd < 32'h20});
        far.pin_a(1'b0);
        repeat (4) @(posedge clk);
        bus(1'b0, CV, 32'h0);
        c1 = rd;
        repeat (20) @(posedge clk);
        cnt_in("stop on b", c1, c1);
        far.pin_a(1'b1);
        far.pin_a(1'b0);
        repeat (4) @(posedge clk);
        rdc("overrun", SR, 32'h2, 32'h2);
        setup(32'h00040080);
        far.pin_a(1'b1);
        repeat (4) @(posedge clk);
        rdc("clock off on b", SR, 32'h100, 32'h0);
        far.pin_a(1'b0);
        setup(32'h00040540);
        far.pin_a(1'b1);
        repeat (4) @(posedge clk);
        bus(1'b0, CV, 32'h0);
        c1 = rd;
        repeat (20) @(posedge clk);
        cnt_in("trigger ignored", c1, c1);
        far.pin_a(1'b0);
        setup(32'h500);
        bus(1'b1, 8'h74, 32'h80);
        far.pin_a(1'b1);
        repeat (4) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        rdc("ext trigger", SR, 32'h80, 32'h80);
        repeat (3) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        cnt_in("ext restart", 1, 10);
        // With the clock enable low for 50 cycles the count holds; only the bus cycles around it may add a few ticks.
        bus(1'b0, CV, 32'h0);
        c1 = rd;
        ce <= 1'b0;
        repeat (50) @(posedge clk);
        ce <= 1'b1;
        cnt_in("clock enable low", c1, c1 + 4);
        setup(32'h200);
        far.pin_b(1'b1);
        far.pin_b(1'b0);
        repeat (4) @(posedge clk);
        cnt_in("b falling trigger", 0, 5);
        bus(1'b1, CMD, 32'h1);
        bus(1'b1, 8'h8c, 32'h5);
        bus(1'b1, MD, 32'h4000);
        bus(1'b1, CMD, 32'ha);
        repeat (60) @(posedge clk);
        cnt_in("compare restart", 0, 5);
        rdc("compare flag", SR, 32'h10, 32'h10);
        complete_run();
    end
endmodule
`default_nettype wire
